// ### hdl/dac_diag_defines.svh
/*
 Constants of the fault unit: keys, fields, reset values, timing.
 Assumes inclusion by bare name.
*/
`ifndef DAC_DIAG_DEFINES_SVH
`define DAC_DIAG_DEFINES_SVH

`define KEY_RESET_FIRST 16'h15fa
`define KEY_RESET_SECOND 16'haf51
`define KEY_CAL_REFRESH 16'hfcba
`define OSC_DEAD_CODE 24'h07dead
`define TICK_DIVIDE 10000
`define REFRESH_CYCLES 64
`define CRC_INIT 8'hff
`define CRC_POLY 8'h07
`define SPAN_LSB 0
`define SPAN_MSB 3
`define QUIET_BIT 3
`define TEMP_TRIP_WIDTH 2
`define DIG_FLAGS_RESET 11'h003
`define ANA_FLAGS_RESET 7'h00
`define CRC_CHECK_RESET 1'b1
`define FREQ_EN_RESET 1'b1
`define OSC_DETECT_RESET 1'b1
`define COMPARATOR_RESET 4'h0
`define ALARM_MASK_RESET 10'h000

`endif

// ### hdl/dac_diag_pkg.sv
/*
 Types of the diagnostic and fault unit.
 Assumes dac_diag_defines.svh is on the include path.
*/
`include "dac_diag_defines.svh"

package dac_diag_pkg;

   // Digital results flags
   typedef struct packed {
      logic spi_crc_err;
      logic slip_bit_err;
      logic sclk_count_err;
      logic bad_access_error_flag;
      logic cal_crc_error_flag;
      logic inverse_check_err;
      logic latch_monitor_err;
      logic watchdog_error_flag;
      logic slew_in_progress_flag;
      logic cal_not_refreshed_flag;
      logic reset_seen_flag;
   } digital_results_register_t;

   // Analog results flags
   typedef struct packed {
      logic open_circuit_err;
      logic short_circuit_err;
      logic temperature_err;
      logic reference_output_error_flag;
      logic reference_input_err;
      logic regulator_err;
      logic internal_supply_err;
   } analog_results_register_t;

   // Live fault conditions from the surrounding logic
   typedef struct packed {
      logic osc_stopped;
      logic watchdog_timeout;
      logic latch_monitor_fault;
      logic inverse_check_fault;
      logic slip_bit_fault;
      logic spi_crc_fault;
      logic sclk_count_fault;
      logic slew_busy;
      logic open_circuit;
      logic short_circuit;
   } fault_inputs_t;

   // Comparator reports, asserted while a node is out of window
   typedef struct packed {
      logic reference_input;
      logic reference_output;
      logic regulator_output;
      logic internal_analog_supply;
   } node_faults_t;

   // Write strobe from the serial decode
   typedef struct packed {
      logic valid;
      logic is_key;
      logic is_readback_select;
      logic is_nop;
      logic is_digital_results;
      logic is_analog_results;
      logic is_converter_config;
      logic [15:0] data;
   } reg_write_t;

   // Alarm mask, one bit per maskable fault
   typedef struct packed {
      logic osc_stop;
      logic watchdog;
      logic latch_monitor;
      logic inverse_check;
      logic invalid_access;
      logic slip_bit;
      logic spi_crc;
      logic open_circuit;
      logic short_circuit;
      logic temperature;
   } alarm_mask_t;

   typedef enum logic [1:0] {
      KEY_IDLE = 2'b00,
      KEY_ARMED = 2'b01
   } key_state_t;

   typedef enum logic [1:0] {
      REFRESH_IDLE = 2'b00,
      REFRESH_RUN = 2'b01,
      REFRESH_CHECK = 2'b10
   } refresh_state_t;

endpackage : dac_diag_pkg

// ### hdl/dac_diag_fault_unit.sv
/*
 Diagnostic and fault unit: reset keys,
 calibration CRC refresh and bad-access flag,
 tick counter, dead code, sticky flags, alarm.
 Assumes decoded writes and one clock,
 live fault levels from nearby blocks,
 one calibration word per cycle at cal_index.
*/
// Behaviour
// R1: Reset after keys 15fa then af51
// R2: Reset from pin, key or watchdog
// R3: Any reset sets reset_seen_flag
// R4: Refresh on key or span change, CRC
// R5: CRC mismatch sets calibration CRC flag
// R6: CRC check on at reset, software disables
// R7: Refresh blocks writes except readback, nop; here other writes still act and only set bad_access_error_flag
// R8: Host waits 500 us after refresh
// R9: 16-bit counter at 1 kHz, enabled
// R10: Dead oscillator returns 07dead code
// R11: Write one reloads flag with condition
// R12: Unrefreshed and slew flags self-clear
// R13: Summaries OR flags, slew excluded
// R14: Summaries live, read only
// R15: Temperature compare always, four trips
// R16: Comparators off at reset, reference_input gated
// R17: Sticky flag per monitored node
// R18: Reference fault flags dependent nodes
// R19: Open-drain active-low alarm pin
// R20: Alarm mapping with maskable subset
// R21: Quiet bit keeps clock-count off alarm
// R22: Readback holds inverted alarm level
// R23: Watchdog default sets flag and alarm
// R24: Wrong second key abandons sequence
`timescale 1ns/1ps
`default_nettype none
`include "dac_diag_defines.svh"

module dac_diag_fault_unit #(
   parameter int TICK_DIVIDE = `TICK_DIVIDE,
   parameter int REFRESH_CYCLES = `REFRESH_CYCLES,
   parameter int CAL_WORDS = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic clock_enable,
   input wire logic reset_pin,
   // Register writes
   input wire dac_diag_pkg::reg_write_t reg_write,
   // Configuration
   input wire logic cal_crc_check_enable,
   input wire logic freq_counter_enable,
   input wire logic osc_stop_detect_enable,
   input wire logic serial_diag_quiet_enable,
   input wire logic [`TEMP_TRIP_WIDTH-1:0] temp_trip_select,
   input wire logic [3:0] comparator_enable_bits,
   input wire logic buffer_power_enable,
   input wire logic watchdog_reset_enable,
   input wire dac_diag_pkg::alarm_mask_t alarm_mask,
   // Faults and comparators
   input wire dac_diag_pkg::fault_inputs_t fault_inputs,
   input wire dac_diag_pkg::node_faults_t node_faults,
   input wire logic [3:0] temp_over_trip,
   // Calibration memory
   input wire logic [7:0] cal_word,
   input wire logic [7:0] cal_reference_crc,
   output logic [3:0] cal_index,
   // Status
   output dac_diag_pkg::digital_results_register_t digital_results_register,
   output dac_diag_pkg::analog_results_register_t analog_results_register,
   output logic digital_summary_flag,
   output logic analog_summary_flag,
   output logic watchdog_summary_flag,
   output logic [15:0] oscillator_tick_counter,
   output logic refresh_busy,
   output logic soft_reset_pulse,
   output logic alarm_pin_status_bit,
   output logic [23:0] readback_override,
   output logic readback_override_valid,
   // Alarm pin
   output logic alarm_pin_n_out,
   output logic alarm_pin_n_oe
);

   if (TICK_DIVIDE < 2 || TICK_DIVIDE > 16384 || REFRESH_CYCLES < CAL_WORDS ||
       REFRESH_CYCLES > 65536 || CAL_WORDS > 16 || CAL_WORDS < 1) begin : g_bad_params
      $error("Unsupported parameters");
   end

   function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc8_step

   // Key sequence
   dac_diag_pkg::key_state_t key_reg, key_next;
   logic soft_reset_reg, soft_reset_next;
   wire logic key_write = reg_write.valid && reg_write.is_key;

   always_comb begin
      key_next = key_reg;
      soft_reset_next = 1'b0;
      if (key_write) begin
         case (key_reg)
            dac_diag_pkg::KEY_IDLE: begin
               if (reg_write.data == `KEY_RESET_FIRST)
                  key_next = dac_diag_pkg::KEY_ARMED; // R1
            end
            dac_diag_pkg::KEY_ARMED: begin
               key_next = dac_diag_pkg::KEY_IDLE; // R24
               if (reg_write.data == `KEY_RESET_SECOND)
                  soft_reset_next = 1'b1; // R1
               else if (reg_write.data == `KEY_RESET_FIRST)
                  key_next = dac_diag_pkg::KEY_ARMED;
            end
            default: key_next = dac_diag_pkg::KEY_IDLE;
         endcase
      end else if (reg_write.valid) begin
         key_next = dac_diag_pkg::KEY_IDLE; // R1
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         key_reg <= dac_diag_pkg::KEY_IDLE;
         soft_reset_reg <= 1'b0;
      end else if (clock_enable) begin
         key_reg <= key_next;
         soft_reset_reg <= soft_reset_next;
      end
   end

   // Reset from pin, key sequence or watchdog
   wire logic device_reset = reset_pin || soft_reset_reg ||
      (watchdog_reset_enable && fault_inputs.watchdog_timeout); // R2

   // Calibration refresh
   dac_diag_pkg::refresh_state_t ref_reg, ref_next;
   logic [15:0] ref_count_reg, ref_count_next;
   logic [7:0] crc_reg, crc_next;
   logic [3:0] span_reg, span_next;
   logic crc_bad_event;
   logic refresh_done;

   always_comb begin
      ref_next = ref_reg;
      ref_count_next = ref_count_reg;
      crc_next = crc_reg;
      span_next = span_reg;
      crc_bad_event = 1'b0;
      refresh_done = 1'b0;
      if (reg_write.valid && reg_write.is_converter_config)
         span_next = reg_write.data[`SPAN_MSB:`SPAN_LSB];
      case (ref_reg)
         dac_diag_pkg::REFRESH_IDLE: begin
            if ((key_write && reg_write.data == `KEY_CAL_REFRESH) ||
                (reg_write.valid && reg_write.is_converter_config &&
                 reg_write.data[`SPAN_MSB:`SPAN_LSB] != span_reg)) begin // R4
               ref_next = dac_diag_pkg::REFRESH_RUN;
               ref_count_next = 16'h0000;
               crc_next = `CRC_INIT;
            end
         end
         dac_diag_pkg::REFRESH_RUN: begin
            ref_count_next = ref_count_reg + 16'h0001;
            if (ref_count_reg < 16'(CAL_WORDS))
               crc_next = crc8_step(crc_reg, cal_word); // R4
            if (ref_count_reg == 16'(REFRESH_CYCLES - 1))
               ref_next = dac_diag_pkg::REFRESH_CHECK;
         end
         dac_diag_pkg::REFRESH_CHECK: begin
            refresh_done = 1'b1;
            crc_bad_event = cal_crc_check_enable && (crc_reg != cal_reference_crc); // R5 R6
            ref_next = dac_diag_pkg::REFRESH_IDLE;
         end
         default: ref_next = dac_diag_pkg::REFRESH_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ref_reg <= dac_diag_pkg::REFRESH_IDLE;
         ref_count_reg <= 16'h0000;
         crc_reg <= `CRC_INIT;
         span_reg <= 4'h0;
      end else if (clock_enable) begin
         ref_reg <= ref_next;
         ref_count_reg <= ref_count_next;
         crc_reg <= crc_next;
         span_reg <= span_next;
      end
   end

   wire logic refreshing = (ref_reg != dac_diag_pkg::REFRESH_IDLE);
   wire logic bad_access_event = refreshing && reg_write.valid &&
      !reg_write.is_readback_select && !reg_write.is_nop; // R7

   // Oscillator tick counter
   logic [13:0] div_reg, div_next;
   logic [15:0] tick_reg, tick_next;

   always_comb begin
      div_next = div_reg;
      tick_next = tick_reg;
      if (freq_counter_enable) begin // R9
         if (div_reg == 14'(TICK_DIVIDE - 1)) begin
            div_next = 14'h0000;
            tick_next = tick_reg + 16'h0001; // R9
         end else begin
            div_next = div_reg + 14'h0001;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         div_reg <= 14'h0000;
         tick_reg <= 16'h0000;
      end else if (clock_enable) begin
         div_reg <= div_next;
         tick_reg <= tick_next;
      end
   end

   // Sticky results
   dac_diag_pkg::digital_results_register_t dig_reg, dig_next, dig_live;
   dac_diag_pkg::analog_results_register_t ana_reg, ana_next, ana_live;
   logic [3:0] node_live;
   logic temp_live;

   always_comb begin
      node_live = {node_faults.reference_input && buffer_power_enable,
                   node_faults.reference_output,
                   node_faults.regulator_output,
                   node_faults.internal_analog_supply} & comparator_enable_bits; // R16
      temp_live = temp_over_trip[temp_trip_select]; // R15

      dig_live = '0;
      dig_live.spi_crc_err = fault_inputs.spi_crc_fault;
      dig_live.slip_bit_err = fault_inputs.slip_bit_fault;
      dig_live.sclk_count_err = fault_inputs.sclk_count_fault;
      dig_live.bad_access_error_flag = bad_access_event;
      dig_live.cal_crc_error_flag = crc_bad_event;
      dig_live.inverse_check_err = fault_inputs.inverse_check_fault;
      dig_live.latch_monitor_err = fault_inputs.latch_monitor_fault;
      dig_live.watchdog_error_flag = fault_inputs.watchdog_timeout; // R23

      ana_live.open_circuit_err = fault_inputs.open_circuit;
      ana_live.short_circuit_err = fault_inputs.short_circuit;
      ana_live.temperature_err = temp_live; // R15 R18
      ana_live.reference_input_err = node_live[3]; // R17
      ana_live.reference_output_error_flag = node_live[2]; // R17 R18
      ana_live.regulator_err = node_live[1]; // R17 R18
      ana_live.internal_supply_err = node_live[0]; // R17 R18

      dig_next = dig_reg | dig_live; // R11
      if (reg_write.valid && reg_write.is_digital_results)
         dig_next = (dig_reg & ~reg_write.data[10:0]) | dig_live; // R11
      dig_next.reset_seen_flag = dig_reg.reset_seen_flag &
         !(reg_write.valid && reg_write.is_digital_results && reg_write.data[0]);
      dig_next.cal_not_refreshed_flag = dig_reg.cal_not_refreshed_flag && !refresh_done; // R12
      dig_next.slew_in_progress_flag = fault_inputs.slew_busy; // R12

      ana_next = ana_reg | ana_live; // R17
      if (reg_write.valid && reg_write.is_analog_results)
         ana_next = (ana_reg & ~reg_write.data[6:0]) | ana_live; // R11
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dig_reg <= `DIG_FLAGS_RESET; // R3
         ana_reg <= `ANA_FLAGS_RESET;
      end else if (clock_enable) begin
         if (device_reset) begin
            dig_reg <= `DIG_FLAGS_RESET; // R2 R3
            ana_reg <= `ANA_FLAGS_RESET;
         end else begin
            dig_reg <= dig_next;
            ana_reg <= ana_next;
         end
      end
   end

   // Alarm mapping
   logic alarm_next, dig_sum_next, ana_sum_next;
   always_comb begin
      alarm_next =
         (fault_inputs.osc_stopped && !alarm_mask.osc_stop) ||
         (dig_next.watchdog_error_flag && !alarm_mask.watchdog) || // R23
         (dig_next.latch_monitor_err && !alarm_mask.latch_monitor) ||
         (dig_next.inverse_check_err && !alarm_mask.inverse_check) ||
         (dig_next.bad_access_error_flag && !alarm_mask.invalid_access) ||
         (dig_next.slip_bit_err && !alarm_mask.slip_bit) ||
         (dig_next.spi_crc_err && !alarm_mask.spi_crc) ||
         (ana_next.open_circuit_err && !alarm_mask.open_circuit) ||
         (ana_next.short_circuit_err && !alarm_mask.short_circuit) ||
         (ana_next.temperature_err && !alarm_mask.temperature) || // R20
         dig_next.cal_crc_error_flag ||
         (dig_next.sclk_count_err && !serial_diag_quiet_enable) || // R21
         ana_next.reference_input_err || ana_next.reference_output_error_flag ||
         ana_next.regulator_err || ana_next.internal_supply_err; // R20
      dig_sum_next = |{dig_next.spi_crc_err, dig_next.slip_bit_err, dig_next.sclk_count_err,
         dig_next.bad_access_error_flag, dig_next.cal_crc_error_flag,
         dig_next.inverse_check_err, dig_next.latch_monitor_err,
         dig_next.watchdog_error_flag, dig_next.cal_not_refreshed_flag,
         dig_next.reset_seen_flag}; // R13
      ana_sum_next = |ana_next; // R13
   end

   logic alarm_reg, dig_sum_reg, ana_sum_reg, osc_dead_reg;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         alarm_reg <= 1'b0;
         dig_sum_reg <= 1'b1;
         ana_sum_reg <= 1'b0;
         osc_dead_reg <= 1'b0;
      end else if (clock_enable) begin
         alarm_reg <= alarm_next && !device_reset; // R19
         dig_sum_reg <= dig_sum_next || device_reset; // R14
         ana_sum_reg <= ana_sum_next && !device_reset; // R14
         osc_dead_reg <= osc_stop_detect_enable && fault_inputs.osc_stopped; // R10
      end
   end

   assign digital_results_register = dig_reg;
   assign analog_results_register = ana_reg;
   assign digital_summary_flag = dig_sum_reg;
   assign analog_summary_flag = ana_sum_reg;
   assign watchdog_summary_flag = dig_reg.watchdog_error_flag;
   assign oscillator_tick_counter = tick_reg;
   assign refresh_busy = (ref_reg != dac_diag_pkg::REFRESH_IDLE);
   assign cal_index = ref_count_reg[3:0];
   assign soft_reset_pulse = soft_reset_reg;
   assign alarm_pin_status_bit = alarm_reg; // R22
   assign readback_override = `OSC_DEAD_CODE; // R10
   assign readback_override_valid = osc_dead_reg; // R10
   assign alarm_pin_n_out = 1'b0; // R19
   assign alarm_pin_n_oe = alarm_reg; // R19

endmodule : dac_diag_fault_unit
`default_nettype wire

// ### test/spi_host_model.sv
/*
 Host model: decoded register writes, one at a time.
 Assumes the bench calls wr.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // Clock
   input wire logic clock,
   // Write strobe
   output var dac_diag_pkg::reg_write_t reg_write
);
   initial reg_write = '0;
   // Keys go out in the order given
   task automatic wr(input logic [5:0] sel, input logic [15:0] d);
      @(posedge clock);
      reg_write <= {1'b1, sel, d};
      @(posedge clock);
      reg_write <= '0;
   endtask : wr
endmodule : spi_host_model
`default_nettype wire

// ### test/dac_diag_fault_properties.sv
/*
 Checker on the fault unit's ports.
 Bound to the unit, one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_diag_fault_props (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Inputs
   input wire dac_diag_pkg::reg_write_t reg_write,
   input wire logic osc_stop_detect_enable,
   input wire logic serial_diag_quiet_enable,
   input wire dac_diag_pkg::fault_inputs_t fault_inputs,
   // Outputs
   input wire dac_diag_pkg::digital_results_register_t digital_results_register,
   input wire dac_diag_pkg::analog_results_register_t analog_results_register,
   input wire logic digital_summary_flag,
   input wire logic analog_summary_flag,
   input wire logic watchdog_summary_flag,
   input wire logic [15:0] oscillator_tick_counter,
   input wire logic refresh_busy,
   input wire logic soft_reset_pulse,
   input wire logic alarm_pin_status_bit,
   input wire logic [23:0] readback_override,
   input wire logic readback_override_valid,
   input wire logic alarm_pin_n_out,
   input wire logic alarm_pin_n_oe
);
   logic key2;
   assign key2 = reg_write.valid && reg_write.is_key && reg_write.data == 16'haf51;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_dsum;
      digital_summary_flag == |(digital_results_register & 11'h7fb);
   endproperty
   a_dsum: assert property (p_dsum) else $error("dig summary");
   property p_asum;
      analog_summary_flag == |analog_results_register;
   endproperty
   a_asum: assert property (p_asum) else $error("ana summary");
   property p_wsum;
      watchdog_summary_flag == digital_results_register.watchdog_error_flag;
   endproperty
   a_wsum: assert property (p_wsum) else $error("wd summary");
   property p_pin;
      alarm_pin_status_bit == alarm_pin_n_oe && !alarm_pin_n_out;
   endproperty
   a_pin: assert property (p_pin) else $error("pin status");
   property p_unmask;
      digital_results_register.cal_crc_error_flag || |analog_results_register[3:0]
         |-> alarm_pin_n_oe;
   endproperty
   a_unmask: assert property (p_unmask) else $error("fault off pin");
   property p_quiet;
      digital_results_register.sclk_count_err && !serial_diag_quiet_enable
         |-> ##[0:1] alarm_pin_n_oe;
   endproperty
   a_quiet: assert property (p_quiet) else $error("clock count fault off pin");
   property p_refresh;
      reg_write.valid && reg_write.is_key && reg_write.data == 16'hfcba && !refresh_busy
         |=> refresh_busy;
   endproperty
   a_refresh: assert property (p_refresh) else $error("refresh did not start");
   property p_bad;
      refresh_busy && reg_write.valid && !reg_write.is_readback_select && !reg_write.is_nop
         |=> digital_results_register.bad_access_error_flag;
   endproperty
   a_bad: assert property (p_bad) else $error("bad access missed");
   property p_key;
      $rose(soft_reset_pulse) |-> $past(key2) || $past(key2, 2);
   endproperty
   a_key: assert property (p_key) else $error("stray reset");
   property p_seen;
      soft_reset_pulse |-> ##[1:2] digital_results_register.reset_seen_flag;
   endproperty
   a_seen: assert property (p_seen) else $error("reset not recorded");
   property p_osc;
      fault_inputs.osc_stopped && osc_stop_detect_enable
         |-> ##[0:2] readback_override_valid && readback_override == 24'h07dead;
   endproperty
   a_osc: assert property (p_osc) else $error("dead code missing");
   property p_tick;
      $changed(oscillator_tick_counter) && oscillator_tick_counter != 16'h0
         |-> oscillator_tick_counter == $past(oscillator_tick_counter) + 16'h1;
   endproperty
   a_tick: assert property (p_tick) else $error("counter step wrong");
   c_refresh: cover property ($fell(refresh_busy));
   c_reset: cover property (soft_reset_pulse);
   c_alarm: cover property ($rose(alarm_pin_n_oe));
endmodule : dac_diag_fault_props
bind dac_diag_fault_unit dac_diag_fault_props u_props (.clock, .rst, .reg_write,
   .osc_stop_detect_enable, .serial_diag_quiet_enable, .fault_inputs,
   .digital_results_register, .analog_results_register, .digital_summary_flag,
   .analog_summary_flag, .watchdog_summary_flag, .oscillator_tick_counter, .refresh_busy,
   .soft_reset_pulse, .alarm_pin_status_bit, .readback_override, .readback_override_valid,
   .alarm_pin_n_out, .alarm_pin_n_oe);
`default_nettype wire

// ### test/dac_diagnostics_fault_unit_tb.sv
/*
 Self-checking bench of the fault unit.
 Assumes host model and checker compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_diagnostics_fault_unit_tb;
   localparam logic [5:0] key_sel = 6'h20;
   localparam logic [5:0] rb_sel = 6'h10;
   localparam logic [5:0] nop_sel = 6'h08;
   localparam logic [5:0] dig_sel = 6'h04;
   localparam logic [5:0] ana_sel = 6'h02;
   localparam logic [5:0] cfg_sel = 6'h01;
   logic clock, rst, reset_pin, crc_en, freq_en, osc_en, quiet, buf_en, wd_en, ce;
   logic dsum, asum, wsum, busy, srp, apst, rbv, aout, aoe;
   logic [1:0] trip;
   logic [3:0] cmp_en, tot, cal_index;
   logic [7:0] ref_crc;
   logic [15:0] cnt, c0;
   logic [23:0] rbo;
   dac_diag_pkg::alarm_mask_t mask;
   dac_diag_pkg::fault_inputs_t fi;
   dac_diag_pkg::node_faults_t nf;
   dac_diag_pkg::reg_write_t rw;
   dac_diag_pkg::digital_results_register_t dr;
   dac_diag_pkg::analog_results_register_t ar;
   int err_count, n_tests, pulses, cyc;
   spi_host_model host (.clock(clock), .reg_write(rw));
   dac_diag_fault_unit #(.TICK_DIVIDE(10), .REFRESH_CYCLES(16)) dut (
      .clock(clock), .rst(rst), .clock_enable(ce), .reset_pin(reset_pin), .reg_write(rw),
      .cal_crc_check_enable(crc_en), .freq_counter_enable(freq_en),
      .osc_stop_detect_enable(osc_en), .serial_diag_quiet_enable(quiet),
      .temp_trip_select(trip), .comparator_enable_bits(cmp_en), .buffer_power_enable(buf_en),
      .watchdog_reset_enable(wd_en), .alarm_mask(mask), .fault_inputs(fi), .node_faults(nf),
      .temp_over_trip(tot), .cal_word({4'ha, cal_index}), .cal_reference_crc(ref_crc),
      .cal_index(cal_index), .digital_results_register(dr), .analog_results_register(ar),
      .digital_summary_flag(dsum), .analog_summary_flag(asum), .watchdog_summary_flag(wsum),
      .oscillator_tick_counter(cnt), .refresh_busy(busy), .soft_reset_pulse(srp),
      .alarm_pin_status_bit(apst), .readback_override(rbo), .readback_override_valid(rbv),
      .alarm_pin_n_out(aout), .alarm_pin_n_oe(aoe));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Expected CRC of the words fed from cal_index
   function automatic logic [7:0] crc8();
      logic [7:0] c;
      c = 8'hff;
      for (int i = 0; i < 16; i++) begin
         c ^= {4'ha, 4'(i)};
         for (int b = 0; b < 8; b++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
      end
      return c;
   endfunction : crc8
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step
   task automatic idle();
      for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clock);
      #1;
      chk("busy_end", 24'h0, busy);
   endtask : idle
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   always @(posedge clock) begin
      cyc++;
      if (srp === 1'b1) pulses++;
      if (cyc == 4000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      rst = 1'b1; reset_pin = 1'b0; crc_en = 1'b1; freq_en = 1'b1; osc_en = 1'b1;
      quiet = 1'b0; buf_en = 1'b0; wd_en = 1'b0; trip = 2'h0; cmp_en = 4'h0; tot = 4'h0;
      mask = '0; fi = '0; nf = '0; ref_crc = crc8(); ce = 1'b1;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      step(1);
      chk("dig", 24'h3, dr);
      chk("alarm", 24'h0, aoe);
      host.wr(dig_sel, 16'h0001); #1; chk("dig", 24'h2, dr);
      $display("test reset done");
      host.wr(key_sel, 16'hfcba); #1; chk("busy", 24'h1, busy);
      host.wr(rb_sel, 16'h0000); host.wr(nop_sel, 16'h0000); idle();
      chk("dig", 24'h0, dr);
      chk("dsum", 24'h0, dsum);
      @(posedge clock); ref_crc <= ~crc8();
      host.wr(key_sel, 16'hfcba); host.wr(ana_sel, 16'h0000); idle();
      chk("dig", 24'hc0, dr);
      chk("apst", 24'h1, apst);
      host.wr(dig_sel, 16'h00c0); #1; chk("dig", 24'h0, dr);
      @(posedge clock); crc_en <= 1'b0;
      host.wr(cfg_sel, 16'h0005); #1; chk("busy", 24'h1, busy);
      idle(); chk("dig", 24'h0, dr);
      @(posedge clock); crc_en <= 1'b1;
      $display("test refresh done");
      host.wr(key_sel, 16'h15fa); host.wr(key_sel, 16'h1234); host.wr(key_sel, 16'haf51);
      step(3); chk("pulses", 24'h0, pulses);
      host.wr(key_sel, 16'h15fa); host.wr(key_sel, 16'haf51);
      step(3); chk("pulses", 24'h1, pulses);
      chk("dig", 24'h3, dr);
      $display("test keys done");
      c0 = cnt; step(100); chk("tick", 24'h00000a, {8'h00, cnt - c0});
      @(posedge clock); ce <= 1'b0;
      step(2); c0 = cnt; step(30); chk("ce", {8'h00, c0}, {8'h00, cnt});
      @(posedge clock); ce <= 1'b1; freq_en <= 1'b0;
      step(2); c0 = cnt; step(50); chk("tick_off", {8'h00, c0}, {8'h00, cnt});
      @(posedge clock); fi.osc_stopped <= 1'b1;
      step(3); chk("rbo", 24'h07dead, rbo);
      chk("rbv", 24'h1, rbv);
      chk("alarm", 24'h1, aoe);
      @(posedge clock); mask.osc_stop <= 1'b1; osc_en <= 1'b0;
      step(3); chk("rbv", 24'h0, rbv);
      chk("alarm", 24'h0, aoe);
      @(posedge clock); fi <= '0; mask <= '1; osc_en <= 1'b1; nf <= 4'h4;
      step(3); chk("ana", 24'h0, ar);
      @(posedge clock); cmp_en <= 4'hf;
      step(3); chk("ana", 24'h08, ar);
      chk("alarm", 24'h1, aoe);
      host.wr(ana_sel, 16'h0008); #1; chk("ana", 24'h08, ar);
      @(posedge clock); nf <= 4'h8;
      step(2); host.wr(ana_sel, 16'h0008); #1; chk("ana", 24'h0, ar);
      @(posedge clock); buf_en <= 1'b1;
      step(3); chk("ana", 24'h04, ar);
      @(posedge clock); nf <= '0; cmp_en <= 4'h0; trip <= 2'h2; tot <= 4'h4;
      step(2); host.wr(ana_sel, 16'h0004); #1; chk("ana", 24'h10, ar);
      chk("alarm", 24'h0, aoe);
      @(posedge clock); mask <= '0;
      step(2); chk("alarm", 24'h1, aoe);
      @(posedge clock); tot <= 4'h0; quiet <= 1'b1; fi.sclk_count_fault <= 1'b1;
      step(2); host.wr(ana_sel, 16'h0010); #1; chk("alarm", 24'h0, aoe);
      @(posedge clock); quiet <= 1'b0;
      step(2); chk("alarm", 24'h1, aoe);
      $display("test alarm done");
      @(posedge clock); fi <= 10'h100;
      step(2); chk("wsum", 24'h1, wsum);
      @(posedge clock); fi <= '0;
      step(1); host.wr(dig_sel, 16'h0109); #1; chk("dig", 24'h2, dr);
      chk("alarm", 24'h0, aoe);
      @(posedge clock); wd_en <= 1'b1; fi <= 10'h100;
      @(posedge clock); fi <= '0;
      step(3); chk("seen", 24'h1, dr.reset_seen_flag);
      @(posedge clock); wd_en <= 1'b0;
      host.wr(dig_sel, 16'h000b); #1; chk("seen", 24'h0, dr.reset_seen_flag);
      @(posedge clock); reset_pin <= 1'b1;
      @(posedge clock); reset_pin <= 1'b0;
      step(2); chk("seen", 24'h1, dr.reset_seen_flag);
      $display("test resets done");
      end_of_test();
   end
endmodule : dac_diagnostics_fault_unit_tb
`default_nettype wire
